// ===== core/aco_pkg.sv
// constants for the axis counter, origin-return and comparator setup block
// assumes one 25 MHz clock and command-code register access
package aco_pkg;
  // write and read command codes
  localparam logic [15:0] WR_IO = 16'h009d;
  localparam logic [15:0] RD_IO = 16'h00dd;
  localparam logic [15:0] WR_OC = 16'h009e;
  localparam logic [15:0] RD_OC = 16'h00de;
  localparam logic [15:0] WR_CMP = 16'h009f;
  localparam logic [15:0] RD_CMP = 16'h00df;
  // writable bits, reserved and read-only bits masked
  localparam logic [31:0] IO_WMASK = 32'h1ff7_ffff;
  localparam logic [31:0] OC_WMASK = 32'h777f_3fff;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // input_and_io_setup fields
  localparam int ENC_FILT_OFF = 8;
  localparam int ENC_TYPE_L = 9;
  localparam int ENC_DIR_REV = 11;
  localparam int IDX_EDGE_SEL = 12;
  localparam int PUL_FILT_OFF = 13;
  localparam int PUL_TYPE_L = 14;
  localparam int PUL_DIR_REV = 16;
  localparam int ENC_IN_OFF = 17;
  localparam int PUL_IN_OFF = 18;
  localparam int EEPROM_FLAG = 19;
  localparam int IDLING_L = 20;
  localparam int GROUP_L = 24;
  localparam int IRQ_GAP_OPT = 28;
  // origin_and_counter_setup fields
  localparam int ORIGIN_L = 0;
  localparam int IDX_CNT_L = 4;
  localparam int C2_SRC_L = 8;
  localparam int C3_SRC_L = 10;
  localparam int C3_BUSY_GATE = 13;
  localparam int CLR_IN_L = 16;
  localparam int CLR_HOME_L = 20;
  localparam int BACKLASH_L = 24;
  localparam int CNT_CTRL_L = 28;
  // comparator_setup fields, comparator 2 sits one stride above 1
  localparam int CMP_SEL_L = 0;
  localparam int CMP_COND_L = 2;
  localparam int CMP_ACT_L = 5;
  localparam int CMP_STRIDE = 8;
  // quadrature input types
  localparam logic [1:0] QT_X1 = 2'b00;
  localparam logic [1:0] QT_X2 = 2'b01;
  localparam logic [1:0] QT_X4 = 2'b10;
  // comparator conditions and actions
  localparam logic [2:0] COND_EQ = 3'b001;
  localparam logic [2:0] COND_EQF = 3'b010;
  localparam logic [2:0] COND_EQB = 3'b011;
  localparam logic [2:0] COND_GT = 3'b100;
  localparam logic [2:0] COND_LT = 3'b101;
  localparam logic [2:0] COND_SLIM = 3'b110;
  localparam logic [1:0] ACT_NOW = 2'b01;
  localparam logic [1:0] ACT_DEC = 2'b10;
  localparam logic [1:0] ACT_SHF = 2'b11;
  // origin methods
  localparam logic [3:0] OM0 = 4'h0;
  localparam logic [3:0] OM3 = 4'h3;
  localparam logic [3:0] OM5 = 4'h5;
  localparam logic [3:0] OM6 = 4'h6;
  localparam logic [3:0] OM7 = 4'h7;
  localparam logic [3:0] OM8 = 4'h8;
  localparam logic [3:0] OM9 = 4'h9;
  localparam logic [3:0] OM10 = 4'ha;
  localparam logic [3:0] OM11 = 4'hb;
  localparam logic [3:0] OM12 = 4'hc;
  // timing
  localparam int CLK_NS = 40;
  localparam int FILT_NS = 150;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int C3_DIV = 4096;
  localparam logic [15:0] C3_MAX = 16'h7fff;
  localparam logic [15:0] C3_MIN = 16'h8000;
  typedef enum logic [5:0] {
    H_IDLE = 6'b00_0001,
    H_SEEK = 6'b00_0010,
    H_STOP = 6'b00_0100,
    H_REV = 6'b00_1000,
    H_EZ = 6'b01_0000,
    H_ZERO = 6'b10_0000
  } aco_home_t;
endpackage

// ===== core/aco_axis.sv
// axis feedback inputs, counters 1-3, origin return 5-12, comparators 1-2
// assumes command pulses, busy and irq come from logic on clk_i
`timescale 1ns/1ps
module aco_axis #(
  parameter int CW = 28
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [15:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  input wire logic encoder_phase_a_i,
  input wire logic encoder_phase_b_i,
  input wire logic encoder_index_i,
  input wire logic pulser_phase_a_i,
  input wire logic pulser_phase_b_i,
  input wire logic origin_sensor_i,
  input wire logic end_limit_i,
  input wire logic counter_clear_input_i,
  input wire logic [2:0] group_select_pin_i,
  input wire logic eeprom_busy_i,
  input wire logic cmd_pulse_i,
  input wire logic cmd_dir_i,
  input wire logic busy_n_i,
  input wire logic backlash_i,
  input wire logic home_start_i,
  input wire logic irq_req_i,
  input wire logic irq_cause_reset_i,
  input wire logic cyclic_tick_i,
  input wire logic [CW-1:0] comparator1_data_i,
  input wire logic [CW-1:0] comparator2_data_i,
  output logic [CW-1:0] counter1_o,
  output logic [CW-1:0] counter2_o,
  output logic [15:0] counter3_o,
  output logic home_stop_o,
  output logic home_stop_now_o,
  output logic home_reverse_o,
  output logic home_done_o,
  output logic [1:0] cmp_met_o,
  output logic cmp_stop_now_o,
  output logic cmp_decel_o,
  output logic preshift_o,
  output logic irq_req_o,
  output logic [2:0] broadcast_group_o,
  output logic [2:0] idling_pulse_count_o
);
  localparam int DW = $clog2(aco_pkg::C3_DIV);
  localparam logic [2:0] FTOP = 3'(aco_pkg::FILT_CYC - 1);

  if (CW < 17 || CW > 32) begin : g_bad
    $error("counter width out of range");
  end

  typedef struct packed {
    logic [10:0] sy1;
    logic [10:0] sy2;
    logic [4:0] flt;
    logic [4:0] fpv;
    logic [4:0][2:0] fcnt;
    logic clr_pv;
    logic [31:0] io;
    logic [31:0] oc;
    logic [31:0] cmp;
    logic [CW-1:0] c1;
    logic [CW-1:0] c2;
    logic [15:0] c3;
    logic [2:0] cdir;
    logic [DW-1:0] div;
    aco_pkg::aco_home_t hs;
    logic [3:0] zcnt;
    logic hstop;
    logic hnow;
    logic hrev;
    logic hdone;
    logic [1:0] met;
    logic cnow;
    logic cdec;
    logic pshf;
    logic gap;
    logic irq;
    logic [2:0] group_select_pin;
    logic [2:0] idling_pulse_count;
    logic [31:0] rdata;
    logic rvalid;
  } aco_st_t;

  aco_st_t s;
  aco_st_t n;
  logic byp;
  logic [1:0] eq;
  logic [1:0] pq;
  logic e_up;
  logic e_dn;
  logic p_up;
  logic p_dn;
  logic c_up;
  logic c_dn;
  logic tick;
  logic zedge;
  logic clr_edge;
  logic fin;
  logic hclr;
  logic [3:0] base;
  logic [2:0] en;
  logic [2:0] cl;
  logic signed [2:0] d3;
  logic signed [16:0] sum3;
  logic [16:0] ab;
  logic [CW-1:0] cv;
  logic [CW-1:0] data;
  logic [1:0] sel;
  logic [1:0] act;
  logic [2:0] cond;
  logic m;

  // returns {up, down} from current and previous phase levels
  function automatic logic [1:0] quad(input logic [1:0] t, input logic a,
                                      input logic b, input logic pa, input logic pb);
    logic ar;
    logic af;
    logic br;
    logic bf;
    ar = a & !pa;
    af = !a & pa;
    br = b & !pb;
    bf = !b & pb;
    case (t)
      aco_pkg::QT_X1: quad = {ar & !b, af & !b};
      aco_pkg::QT_X2: quad = {(ar & !b) | (af & b), (ar & b) | (af & !b)};
      aco_pkg::QT_X4: quad = {(ar & !b) | (br & a) | (af & b) | (bf & !a),
                              (ar & b) | (br & !a) | (af & !b) | (bf & a)};
      default: quad = {ar & !br, br & !ar};
    endcase
  endfunction

  function automatic logic signed [2:0] step(input logic up, input logic dn);
    step = $signed({2'b00, up}) - $signed({2'b00, dn});
  endfunction

  always_comb begin
    n = s;
    byp = 1'b0;
    n.hstop = 1'b0;
    n.hnow = 1'b0;
    n.hdone = 1'b0;
    n.cnow = 1'b0;
    n.cdec = 1'b0;
    n.pshf = 1'b0;
    n.rvalid = 1'b0;
    fin = 1'b0;
    hclr = 1'b0;
    n.sy1 = {group_select_pin_i, counter_clear_input_i, end_limit_i, origin_sensor_i,
             pulser_phase_b_i, pulser_phase_a_i, encoder_index_i, encoder_phase_b_i,
             encoder_phase_a_i};
    n.sy2 = s.sy1;
    n.fpv = s.flt;
    // glitch filter: accept a level once it has stood FILT_CYC samples
    for (int i = 0; i < 5; i++) begin
      byp = (i < 3) ? s.io[aco_pkg::ENC_FILT_OFF] : s.io[aco_pkg::PUL_FILT_OFF];
      if (s.sy2[i] == s.flt[i]) begin
        n.fcnt[i] = 3'h0;
      end else if (byp || s.fcnt[i] == FTOP) begin
        n.flt[i] = s.sy2[i];
        n.fcnt[i] = 3'h0;
      end else begin
        n.fcnt[i] = s.fcnt[i] + 3'h1;
      end
    end
    eq = quad(s.io[aco_pkg::ENC_TYPE_L +: 2], s.flt[0], s.flt[1], s.fpv[0], s.fpv[1]);
    pq = quad(s.io[aco_pkg::PUL_TYPE_L +: 2], s.flt[3], s.flt[4], s.fpv[3], s.fpv[4]);
    if (s.io[aco_pkg::ENC_IN_OFF]) eq = 2'b00;
    if (s.io[aco_pkg::PUL_IN_OFF]) pq = 2'b00;
    if (s.io[aco_pkg::ENC_DIR_REV]) eq = {eq[0], eq[1]};
    if (s.io[aco_pkg::PUL_DIR_REV]) pq = {pq[0], pq[1]};
    e_up = eq[1];
    e_dn = eq[0];
    p_up = pq[1];
    p_dn = pq[0];
    c_up = cmd_pulse_i & cmd_dir_i;
    c_dn = cmd_pulse_i & !cmd_dir_i;
    zedge = s.io[aco_pkg::IDX_EDGE_SEL] ? (s.flt[2] & !s.fpv[2])
                                        : (!s.flt[2] & s.fpv[2]);
    n.clr_pv = s.sy2[7];
    clr_edge = s.sy2[7] & !s.clr_pv;
    n.div = s.div + DW'(1);
    tick = &s.div;

    // origin return sequencer
    case (s.oc[aco_pkg::ORIGIN_L +: 4])
      aco_pkg::OM9: base = aco_pkg::OM0;
      aco_pkg::OM10: base = aco_pkg::OM3;
      aco_pkg::OM11: base = aco_pkg::OM5;
      aco_pkg::OM12: base = aco_pkg::OM8;
      default: base = s.oc[aco_pkg::ORIGIN_L +: 4];
    endcase
    case (s.hs)
      aco_pkg::H_IDLE: begin
        if (home_start_i && s.oc[aco_pkg::ORIGIN_L +: 4] >= aco_pkg::OM5 &&
            s.oc[aco_pkg::ORIGIN_L +: 4] <= aco_pkg::OM12) begin
          n.hs = aco_pkg::H_SEEK;
        end
      end
      aco_pkg::H_SEEK: begin
        if (s.sy2[5]) begin
          n.hstop = 1'b1;
          n.hs = aco_pkg::H_STOP;
        end
      end
      aco_pkg::H_STOP: begin
        if (busy_n_i) begin
          if (base == aco_pkg::OM0 || base == aco_pkg::OM3) begin
            fin = 1'b1;
          end else begin
            n.hrev = 1'b1;
            n.hs = aco_pkg::H_REV;
          end
        end
      end
      aco_pkg::H_REV: begin
        if (base == aco_pkg::OM8) begin
          if (!s.sy2[6]) begin
            n.zcnt = 4'h0;
            n.hs = aco_pkg::H_EZ;
          end
        end else if (!s.sy2[5]) begin
          if (base == aco_pkg::OM6) begin
            n.hnow = 1'b1;
            n.hrev = 1'b0;
            fin = 1'b1;
          end else begin
            n.zcnt = 4'h0;
            n.hs = aco_pkg::H_EZ;
          end
        end
      end
      aco_pkg::H_EZ: begin
        if (zedge) begin
          if (s.zcnt == s.oc[aco_pkg::IDX_CNT_L +: 4]) begin
            n.hrev = 1'b0;
            n.hstop = (base == aco_pkg::OM5);
            n.hnow = (base != aco_pkg::OM5);
            fin = 1'b1;
          end else begin
            n.zcnt = s.zcnt + 4'h1;
          end
        end
      end
      aco_pkg::H_ZERO: begin
        if (s.c2 == '0) begin
          n.hnow = 1'b1;
          n.hdone = 1'b1;
          n.hs = aco_pkg::H_IDLE;
        end
      end
      default: n.hs = aco_pkg::H_IDLE;
    endcase
    if (fin) begin
      hclr = (base != aco_pkg::OM6) || !s.sy2[6];
      if (s.oc[aco_pkg::ORIGIN_L +: 4] >= aco_pkg::OM9) begin
        n.hs = aco_pkg::H_ZERO;
      end else begin
        n.hdone = 1'b1;
        n.hs = aco_pkg::H_IDLE;
      end
    end

    // counters
    for (int k = 0; k < 3; k++) begin
      en[k] = s.oc[aco_pkg::CNT_CTRL_L + k] &&
              (!backlash_i || s.oc[aco_pkg::BACKLASH_L + k]);
      cl[k] = (clr_edge && s.oc[aco_pkg::CLR_IN_L + k]) ||
              (hclr && s.oc[aco_pkg::CLR_HOME_L + k]);
    end
    if (s.oc[aco_pkg::C3_BUSY_GATE] && busy_n_i) en[2] = 1'b0;
    if (cl[0]) begin
      n.c1 = '0;
    end else if (en[0] && cmd_pulse_i) begin
      n.c1 = s.c1 + CW'(step(c_up, c_dn));
      n.cdir[0] = c_up;
    end
    case (s.oc[aco_pkg::C2_SRC_L +: 2])
      2'b00: eq = {e_up, e_dn};
      2'b01: eq = {c_up, c_dn};
      2'b10: eq = {p_up, p_dn};
      default: eq = 2'b00;
    endcase
    if (cl[1]) begin
      n.c2 = '0;
    end else if (en[1] && (eq[1] ^ eq[0])) begin
      n.c2 = s.c2 + CW'(step(eq[1], eq[0]));
      n.cdir[1] = eq[1];
    end
    case (s.oc[aco_pkg::C3_SRC_L +: 3])
      3'b000: d3 = step(c_up, c_dn);
      3'b001: d3 = step(e_up, e_dn);
      3'b010: d3 = step(p_up, p_dn);
      3'b011: d3 = step(tick, 1'b0);
      3'b100: d3 = step(c_up, c_dn) - step(e_up, e_dn);
      3'b101: d3 = step(p_up, p_dn) - step(c_up, c_dn);
      3'b110: d3 = step(p_up, p_dn) - step(e_up, e_dn);
      default: d3 = 3'sd0;
    endcase
    sum3 = $signed({s.c3[15], s.c3}) + 17'(d3);
    if (cl[2]) begin
      n.c3 = 16'h0000;
    end else if (en[2] && d3 != 3'sd0) begin
      if (sum3[16] != sum3[15]) begin
        n.c3 = sum3[16] ? aco_pkg::C3_MIN : aco_pkg::C3_MAX;
      end else begin
        n.c3 = sum3[15:0];
      end
      n.cdir[2] = !d3[2];
    end

    // comparators 1 and 2
    ab = s.c3[15] ? 17'(~{1'b1, s.c3} + 17'h0_0001) : {1'b0, s.c3};
    for (int j = 0; j < 2; j++) begin
      sel = s.cmp[j * aco_pkg::CMP_STRIDE + aco_pkg::CMP_SEL_L +: 2];
      cond = s.cmp[j * aco_pkg::CMP_STRIDE + aco_pkg::CMP_COND_L +: 3];
      act = s.cmp[j * aco_pkg::CMP_STRIDE + aco_pkg::CMP_ACT_L +: 2];
      data = (j == 0) ? comparator1_data_i : comparator2_data_i;
      cv = (sel == 2'b00) ? s.c1 : (sel == 2'b01) ? s.c2 : CW'(ab);
      case (cond)
        aco_pkg::COND_EQ: m = sel != 2'b11 && data == cv;
        aco_pkg::COND_EQF: m = sel != 2'b11 && data == cv && s.cdir[sel];
        aco_pkg::COND_EQB: m = sel != 2'b11 && data == cv && !s.cdir[sel];
        aco_pkg::COND_GT: m = sel != 2'b11 && $signed(data) > $signed(cv);
        aco_pkg::COND_LT: m = sel != 2'b11 && $signed(data) < $signed(cv);
        aco_pkg::COND_SLIM: m = (j == 0) ? $signed(data) < $signed(s.c1)
                                         : $signed(data) > $signed(s.c1);
        default: m = 1'b0;
      endcase
      n.met[j] = m;
      if (m && !s.met[j]) begin
        if (act == aco_pkg::ACT_NOW) n.cnow = 1'b1;
        if (act == aco_pkg::ACT_DEC) n.cdec = 1'b1;
        if (act == aco_pkg::ACT_SHF) n.pshf = 1'b1;
      end
    end

    // interrupt gap, cause reset wins over the cyclic tick
    if (irq_cause_reset_i && s.io[aco_pkg::IRQ_GAP_OPT]) begin
      n.gap = 1'b1;
    end else if (cyclic_tick_i) begin
      n.gap = 1'b0;
    end
    n.irq = irq_req_i && !n.gap;
    n.group_select_pin = (s.io[aco_pkg::GROUP_L +: 3] == 3'b000) ? s.sy2[10:8]
                                                    : s.io[aco_pkg::GROUP_L +: 3];
    n.idling_pulse_count = (s.io[aco_pkg::IDLING_L +: 3] == 3'b000) ? 3'b000
                                                     : s.io[aco_pkg::IDLING_L +: 3] - 3'b001;

    // command-code register access
    if (cmd_wr_i) begin
      if (cmd_code_i == aco_pkg::WR_IO) begin
        n.io = cmd_wdata_i & aco_pkg::IO_WMASK;
      end else if (cmd_code_i == aco_pkg::WR_OC) begin
        n.oc = cmd_wdata_i & aco_pkg::OC_WMASK;
      end else if (cmd_code_i == aco_pkg::WR_CMP) begin
        n.cmp = cmd_wdata_i;
      end
    end
    if (cmd_rd_i) begin
      n.rvalid = 1'b1;
      if (cmd_code_i == aco_pkg::RD_IO) begin
        n.rdata = s.io;
        n.rdata[aco_pkg::EEPROM_FLAG] = eeprom_busy_i;
      end else if (cmd_code_i == aco_pkg::RD_OC) begin
        n.rdata = s.oc;
      end else if (cmd_code_i == aco_pkg::RD_CMP) begin
        n.rdata = s.cmp;
      end else begin
        n.rdata = 32'h0000_0000;
        n.rvalid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.io <= aco_pkg::REG_RST;
      s.oc <= aco_pkg::REG_RST;
      s.cmp <= aco_pkg::REG_RST;
      s.hs <= aco_pkg::H_IDLE;
    end else begin
      s <= n;
    end
  end

  assign cmd_rdata_o = s.rdata;
  assign cmd_rvalid_o = s.rvalid;
  assign counter1_o = s.c1;
  assign counter2_o = s.c2;
  assign counter3_o = s.c3;
  assign home_stop_o = s.hstop;
  assign home_stop_now_o = s.hnow;
  assign home_reverse_o = s.hrev;
  assign home_done_o = s.hdone;
  assign cmp_met_o = s.met;
  assign cmp_stop_now_o = s.cnow;
  assign cmp_decel_o = s.cdec;
  assign preshift_o = s.pshf;
  assign irq_req_o = s.irq;
  assign broadcast_group_o = s.group_select_pin;
  assign idling_pulse_count_o = s.idling_pulse_count;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence ez_last;
    s.hs == aco_pkg::H_EZ && zedge && s.zcnt == s.oc[aco_pkg::IDX_CNT_L +: 4];
  endsequence

  AST_FILTER: assert property (s.flt[0] != s.fpv[0] && !$past(s.io[8], 1)
    |-> $past(s.sy2[0], 1) == s.flt[0] && $past(s.sy2[0], 4) == s.flt[0])
    else $error("encoder phase a passed the filter too early");
  AST_X4: assert property (s.io[10:9] == aco_pkg::QT_X4 && !s.io[17] && !s.io[11]
    && s.flt[0] && !s.fpv[0] && !s.flt[1] && !s.fpv[1] |-> e_up && !e_dn)
    else $error("x4 forward edge not counted up");
  AST_PULSER_INPUT_OFF: assert property (s.io[aco_pkg::PUL_IN_OFF] |-> !p_up && !p_dn)
    else $error("pulser counted while disabled");
  AST_GROUP: assert property (s.io[26:24] != 3'b000
    |=> broadcast_group_o == $past(s.io[26:24]))
    else $error("group number not taken from setting");
  AST_GAP: assert property (s.io[aco_pkg::IRQ_GAP_OPT] && irq_cause_reset_i
    |=> !irq_req_o)
    else $error("interrupt request not held off");
  AST_C3SAT: assert property (s.c3 == aco_pkg::C3_MAX |=> s.c3 != aco_pkg::C3_MIN)
    else $error("counter 3 wrapped past its maximum");
  AST_SLIM: assert property (s.cmp[4:2] == aco_pkg::COND_SLIM
    && $signed(comparator1_data_i) < $signed(s.c1) |=> cmp_met_o[0])
    else $error("positive software limit not met");
  AST_ACT: assert property (cmp_met_o[0] && !$past(cmp_met_o[0])
    && $past(s.cmp[6:5]) == aco_pkg::ACT_NOW |-> cmp_stop_now_o)
    else $error("comparator 1 stop not issued");
  AST_EEP: assert property (cmd_rd_i && cmd_code_i == aco_pkg::RD_IO
    |=> cmd_rvalid_o && cmd_rdata_o[19] == $past(eeprom_busy_i))
    else $error("eeprom flag not reported");
  AST_M7: assert property (ez_last ##0 base == aco_pkg::OM7
    |=> home_stop_now_o && !home_reverse_o)
    else $error("method 7 did not stop at index count");
  AST_HCLR: assert property (hclr && s.oc[aco_pkg::CLR_HOME_L] |=> counter1_o == '0)
    else $error("counter 1 not cleared at origin");
endmodule

// ===== tb/aco_feedback.sv
// far-side model: encoder phases from quad(); pulser phases, index, origin and limit sensors held low
// assumes the bench calls quad(); every edge lands on a falling clock edge
`timescale 1ns/1ps
module aco_feedback (
  input wire logic clk_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_z_o,
  output logic pul_a_o,
  output logic pul_b_o,
  output logic origin_o,
  output logic limit_o
);
  initial begin
    {enc_a_o, enc_b_o, enc_z_o, pul_a_o, pul_b_o, origin_o, limit_o} = 7'h00;
  end
  // one quarter step each 8 clocks, well past the glitch filter window
  task automatic quad(input int cycles, input bit fwd);
    logic [1:0] k;
    k = 2'b00;
    repeat (cycles * 4) begin
      k = fwd ? k + 2'b01 : k - 2'b01;
      repeat (8) @(negedge clk_i);
      enc_a_o = k[0] ^ k[1];
      enc_b_o = k[1];
    end
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ===== tb/tb_axis_counter_origin_compare_config.sv
// bench for the axis setup block: command-code access and encoder counting
// assumes aco_feedback as the far side and a 25 MHz clock
`timescale 1ns/1ps
module tb_axis_counter_origin_compare_config;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, clr = 1'b0, eep = 1'b0;
  logic [15:0] code = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0] group_select_pin = 3'h6;
  logic [31:0] rdata;
  logic rvalid;
  logic ea, eb, ez, pa, pb, origin_sensor, el;
  logic [27:0] c2;
  logic [2:0] bgrp, idling_pulse_count;
  logic cpul = 1'b0, cdir = 1'b1, bsyn = 1'b1, hst = 1'b0;
  logic ireq = 1'b0, icr = 1'b0, ctk = 1'b0, saw_stop = 1'b0;
  logic [27:0] cd1 = 28'h000_0000;
  logic [27:0] c1;
  logic [1:0] met;
  logic cstop, irqo;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  aco_feedback far (.clk_i(clk_i), .enc_a_o(ea), .enc_b_o(eb), .enc_z_o(ez),
    .pul_a_o(pa), .pul_b_o(pb), .origin_o(origin_sensor), .limit_o(el));
  aco_axis #(.CW(28)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_wr_i(wr),
    .cmd_rd_i(rd), .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata),
    .cmd_rvalid_o(rvalid), .encoder_phase_a_i(ea), .encoder_phase_b_i(eb),
    .encoder_index_i(ez), .pulser_phase_a_i(pa), .pulser_phase_b_i(pb),
    .origin_sensor_i(origin_sensor), .end_limit_i(el), .counter_clear_input_i(clr),
    .group_select_pin_i(group_select_pin), .eeprom_busy_i(eep), .cmd_pulse_i(cpul),
    .cmd_dir_i(cdir), .busy_n_i(bsyn), .backlash_i(1'b0), .home_start_i(hst),
    .irq_req_i(ireq), .irq_cause_reset_i(icr), .cyclic_tick_i(ctk),
    .comparator1_data_i(cd1), .comparator2_data_i(28'h000_0000),
    .counter1_o(c1), .counter2_o(c2), .counter3_o(), .home_stop_o(),
    .home_stop_now_o(), .home_reverse_o(), .home_done_o(), .cmp_met_o(met),
    .cmp_stop_now_o(cstop), .cmp_decel_o(), .preshift_o(), .irq_req_o(irqo),
    .broadcast_group_o(bgrp), .idling_pulse_count_o(idling_pulse_count));
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // stop pulse stands one cycle, so catch it across a falling edge
  always @(negedge clk_i) begin
    if (cstop) saw_stop <= 1'b1;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] c, input logic [31:0] d);
    @(negedge clk_i);
    {wr, code, wdata} = {1'b1, c, d};
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  // read answer comes exactly one cycle after the strobe
  task automatic rd_chk(input logic [15:0] c, input logic [31:0] exp);
    @(negedge clk_i);
    {rd, code} = {1'b1, c};
    @(negedge clk_i);
    rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask
  task automatic t_regs();
    wr_reg(aco_pkg::WR_IO, 32'hffff_ffff);
    rd_chk(aco_pkg::RD_IO, aco_pkg::IO_WMASK);
    eep = 1'b1;
    rd_chk(aco_pkg::RD_IO, aco_pkg::IO_WMASK | 32'h0008_0000);
    eep = 1'b0;
    wr_reg(aco_pkg::WR_OC, 32'hffff_ffff);
    rd_chk(aco_pkg::RD_OC, aco_pkg::OC_WMASK);
    wr_reg(aco_pkg::WR_CMP, 32'h0000_5a3c);
    rd_chk(aco_pkg::RD_CMP, 32'h0000_5a3c);
  endtask
  task automatic t_group_idle();
    wr_reg(aco_pkg::WR_IO, 32'h0550_0000);
    repeat (3) @(negedge clk_i);
    chk({29'h0, bgrp}, 32'h5);
    chk({29'h0, idling_pulse_count}, 32'h4);
    wr_reg(aco_pkg::WR_IO, 32'h0000_0000);
    repeat (6) @(negedge clk_i);
    chk({29'h0, bgrp}, {29'h0, group_select_pin});
    chk({29'h0, idling_pulse_count}, 32'h0);
  endtask
  // counter 2 on encoder phases, cleared by the clear input before each run
  task automatic count_run(input logic [31:0] io, input bit fwd, input int exp);
    wr_reg(aco_pkg::WR_OC, 32'h2002_0000);
    wr_reg(aco_pkg::WR_IO, io);
    clr = 1'b1;
    repeat (6) @(negedge clk_i);
    clr = 1'b0;
    repeat (6) @(negedge clk_i);
    chk({{4{c2[27]}}, c2}, 32'h0);
    far.quad(3, fwd);
    repeat (12) @(negedge clk_i);
    chk({{4{c2[27]}}, c2}, exp);
  endtask
  task automatic t_encoder();
    count_run(32'h0000_0000, 1'b1, 3);
    count_run(32'h0000_0200, 1'b1, 6);
    count_run(32'h0000_0400, 1'b1, 12);
    count_run(32'h0000_0400, 1'b0, -12);
    count_run(32'h0000_0600, 1'b1, 0);
    count_run(32'h0000_0c00, 1'b1, -12);
    count_run(32'h0002_0400, 1'b1, 0);
    count_run(32'h0000_0500, 1'b1, 12);
  endtask
  // counter 1 on command pulses, comparator 1 soft limit, interrupt gap
  task automatic t_cmd_irq();
    wr_reg(aco_pkg::WR_OC, 32'h1000_0000);
    wr_reg(aco_pkg::WR_CMP, 32'h0000_0038);
    cd1 = 28'h000_0002;
    cdir = 1'b1;
    repeat (3) begin
      @(negedge clk_i);
      cpul = 1'b1;
      @(negedge clk_i);
      cpul = 1'b0;
    end
    repeat (3) @(negedge clk_i);
    chk({4'h0, c1}, 32'h3);
    chk({30'h0, met}, 32'h1);
    chk({31'h0, saw_stop}, 32'h1);
    cdir = 1'b0;
    repeat (2) begin
      @(negedge clk_i);
      cpul = 1'b1;
      @(negedge clk_i);
      cpul = 1'b0;
    end
    repeat (3) @(negedge clk_i);
    chk({4'h0, c1}, 32'h1);
    chk({30'h0, met}, 32'h0);
    wr_reg(aco_pkg::WR_IO, 32'h1000_0000);
    ireq = 1'b1;
    repeat (2) @(negedge clk_i);
    chk({31'h0, irqo}, 32'h1);
    icr = 1'b1;
    @(negedge clk_i);
    icr = 1'b0;
    chk({31'h0, irqo}, 32'h0);
    repeat (2) @(negedge clk_i);
    chk({31'h0, irqo}, 32'h0);
    ctk = 1'b1;
    @(negedge clk_i);
    ctk = 1'b0;
    chk({31'h0, irqo}, 32'h1);
    ireq = 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_regs();
    t_group_idle();
    t_encoder();
    t_cmd_irq();
    wrap_up();
  end
endmodule
